// [hdl/keypad_io_pkg.sv]
package keypad_io_pkg;

    // ========================================================================
    // Register map
    // ========================================================================
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_KEY_STAT = 8'h04;
    localparam logic [7:0] ADDR_KEY_LO   = 8'h08;
    localparam logic [7:0] ADDR_KEY_HI   = 8'h0C;
    localparam logic [7:0] ADDR_SW_STAT  = 8'h10;
    localparam logic [7:0] ADDR_SW_VAL   = 8'h14;
    localparam logic [7:0] ADDR_SEG_SRC  = 8'h18;
    localparam logic [7:0] ADDR_SEG_DST  = 8'h1C;

    // ========================================================================
    // Status bit positions
    // ========================================================================
    localparam int KS_LETTER = 6;
    localparam int KS_DIGIT  = 7;
    localparam int KS_DONE   = 8;
    localparam int KS_OVF    = 9;
    localparam int SS_DONE   = 0;
    localparam int SS_ERR    = 1;
    localparam int SS_HOLD   = 2;

    // ========================================================================
    // Values and timing
    // ========================================================================
    localparam logic [3:0]  KEY_STABLE_LAST  = 4'h7;
    localparam logic [4:0]  FIRST_LETTER     = 5'h0A;
    localparam logic [3:0]  BCD_MAX          = 4'h9;
    localparam logic [1:0]  LAST_STEP        = 2'h3;
    localparam logic [35:0] DEC_LIMIT_SINGLE = 36'h00000270F;
    localparam logic [35:0] DEC_LIMIT_DOUBLE = 36'h005F5E0FF;
    localparam int          SW_INTERVAL_MS   = 100;
    localparam int          CLK_MHZ          = 125;
    localparam int          SW_INTERVAL_CYC  = SW_INTERVAL_MS * 1000 * CLK_MHZ;
    localparam int          SW_CNT_W         = 24;

    // ========================================================================
    // Types
    // ========================================================================
    typedef struct packed {
        logic segPolarity;
        logic groupsTwo;
        logic switchDrive;
        logic hexEntry;
        logic doubleWord;
        logic keyDrive;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '0;

    typedef struct packed {
        logic [7:0] addr;
        logic       write;
        logic       valid;
    } ahb_req_t;

    typedef enum logic [1:0] {
        KP_IDLE,
        KP_SEEK,
        KP_STABLE,
        KP_HELD
    } kp_state_t;

endpackage

// [hdl/keypad_switch_segment_io.sv]
`timescale 1ns/1ps
module keypad_switch_segment_io
    import keypad_io_pkg::*;
#(
    parameter int unsigned SW_INTERVAL_CYCLES = SW_INTERVAL_CYC
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        scanTick,
    input  wire logic [3:0]  keypadSense,
    output logic      [3:0]  keypadStrobes,
    input  wire logic [7:0]  switchSense,
    output logic      [3:0]  switchStrobes
);

    // ========================================================================
    // Functions
    // ========================================================================
    function automatic logic [3:0] oneHot(input logic [1:0] idx);
        oneHot = 4'h1 << idx;
    endfunction

    function automatic logic [1:0] lowestBit(input logic [3:0] v);
        if (v[0]) begin
            lowestBit = 2'h0;
        end else if (v[1]) begin
            lowestBit = 2'h1;
        end else if (v[2]) begin
            lowestBit = 2'h2;
        end else begin
            lowestBit = 2'h3;
        end
    endfunction

    function automatic logic [35:0] accumulate(input logic [31:0] v,
                                               input logic [3:0]  d,
                                               input logic        hex);
        logic [35:0] w;
        w = {4'h0, v};
        if (hex) begin
            accumulate = {v, d};
        end else begin
            accumulate = (w << 3) + (w << 1) + {32'h0, d};
        end
    endfunction

    function automatic logic [15:0] mulTenAdd(input logic [15:0] v,
                                              input logic [3:0]  d);
        mulTenAdd = (v << 3) + (v << 1) + {12'h0, d};
    endfunction

    function automatic logic [15:0] bcdToBin(input logic [15:0] raw);
        logic [15:0] acc;
        acc = {12'h0, raw[15:12]};
        acc = mulTenAdd(acc, raw[11:8]);
        acc = mulTenAdd(acc, raw[7:4]);
        bcdToBin = mulTenAdd(acc, raw[3:0]);
    endfunction

    function automatic logic [15:0] putNibble(input logic [15:0] raw,
                                              input logic [1:0]  idx,
                                              input logic [3:0]  d);
        logic [15:0] r;
        r = raw;
        r[idx*4 +: 4] = d;
        putNibble = r;
    endfunction

    function automatic logic [7:0] segPattern(input logic [3:0] n);
        case (n)
            4'h0: segPattern = 8'h3F;
            4'h1: segPattern = 8'h06;
            4'h2: segPattern = 8'h5B;
            4'h3: segPattern = 8'h4F;
            4'h4: segPattern = 8'h66;
            4'h5: segPattern = 8'h6D;
            4'h6: segPattern = 8'h7D;
            4'h7: segPattern = 8'h27;
            4'h8: segPattern = 8'h7F;
            4'h9: segPattern = 8'h6F;
            4'hA: segPattern = 8'h77;
            4'hB: segPattern = 8'h7C;
            4'hC: segPattern = 8'h39;
            4'hD: segPattern = 8'h5E;
            4'hE: segPattern = 8'h79;
            default: segPattern = 8'h71;
        endcase
    endfunction

    // ========================================================================
    // Declarations
    // ========================================================================
    ahb_req_t              reqFf;
    logic      [31:0]      hrdataFf;
    logic      [31:0]      rdMux;
    ctrl_t                 ctrlFf;
    logic                  wrEn;
    logic                  addrOk;
    kp_state_t             kpStateFf;
    logic      [1:0]       keyRowFf;
    logic      [3:0]       candKeyFf;
    logic      [3:0]       stableCntFf;
    logic      [31:0]      keyValueFf;
    logic      [5:0]       funcFlagsFf;
    logic                  keyDoneFf;
    logic                  keyOvfFf;
    logic                  candLost;
    logic                  keyAccept;
    logic                  keyWrap;
    logic                  isLetter;
    logic                  letterSeen;
    logic                  digitSeen;
    logic      [35:0]      nxtKeyValue;
    logic                  entryOvf;
    logic      [1:0]       swStepFf;
    logic                  swHoldFf;
    logic [SW_CNT_W-1:0]   swCntFf;
    logic      [15:0]      swRaw1Ff;
    logic      [15:0]      swRaw2Ff;
    logic      [15:0]      swVal1Ff;
    logic      [15:0]      swVal2Ff;
    logic                  swDoneFf;
    logic                  swErrFf;
    logic                  swStep;
    logic                  swWrap;
    logic                  swBadDigit;
    logic      [15:0]      nxtRaw1;
    logic      [15:0]      nxtRaw2;
    logic      [15:0]      segSrcFf;
    logic      [15:0]      segDstFf;

    // ========================================================================
    // Bus slave
    // ========================================================================
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdataFf;
    assign addrOk    = (haddr[31:5] == 27'h0) && (haddr[1:0] == 2'h0);
    assign wrEn      = reqFf.valid && reqFf.write;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reqFf <= '0;
        end else begin
            reqFf.valid <= hsel && hready && htrans[1] && addrOk;
            reqFf.write <= hwrite;
            reqFf.addr  <= haddr[7:0];
        end
    end

    always_comb begin
        rdMux = 32'h0;
        case (haddr[7:0])
            ADDR_CTRL:     rdMux = {26'h0, ctrlFf};
            ADDR_KEY_STAT: rdMux = {22'h0, keyOvfFf, keyDoneFf, digitSeen,
                                    letterSeen, funcFlagsFf};
            ADDR_KEY_LO:   rdMux = {16'h0, keyValueFf[15:0]};
            ADDR_KEY_HI:   rdMux = {16'h0, keyValueFf[31:16]};
            ADDR_SW_STAT:  rdMux = {29'h0, swHoldFf, swErrFf, swDoneFf};
            ADDR_SW_VAL:   rdMux = {swVal2Ff, swVal1Ff};
            ADDR_SEG_SRC:  rdMux = {16'h0, segSrcFf};
            ADDR_SEG_DST:  rdMux = {16'h0, segDstFf};
            default:       rdMux = 32'h0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            hrdataFf <= 32'h0;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            hrdataFf <= addrOk ? rdMux : 32'h0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctrlFf <= CTRL_RESET;
        end else if (wrEn && reqFf.addr == ADDR_CTRL) begin
            ctrlFf <= ctrl_t'(hwdata[5:0]);
        end
    end

    // ========================================================================
    // Keypad scanner
    // ========================================================================
    assign keypadStrobes = (kpStateFf == KP_IDLE) ? 4'h0 : oneHot(keyRowFf);
    assign candLost  = (candKeyFf[3:2] == keyRowFf) &&
                       !keypadSense[candKeyFf[1:0]];
    assign keyWrap   = scanTick && ctrlFf.keyDrive && keyRowFf == LAST_STEP;
    assign keyAccept = scanTick && ctrlFf.keyDrive &&
                       kpStateFf == KP_STABLE && !candLost &&
                       stableCntFf == KEY_STABLE_LAST;
    assign isLetter   = {1'b0, candKeyFf} >= FIRST_LETTER;
    assign letterSeen = kpStateFf == KP_HELD && isLetter;
    assign digitSeen  = kpStateFf == KP_HELD && !isLetter;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            kpStateFf   <= KP_IDLE;
            keyRowFf    <= 2'h0;
            candKeyFf   <= 4'h0;
            stableCntFf <= 4'h0;
        end else if (!ctrlFf.keyDrive) begin
            kpStateFf <= KP_IDLE;
            keyRowFf  <= 2'h0;
        end else begin
            case (kpStateFf)
                KP_IDLE: begin
                    kpStateFf <= KP_SEEK;
                    keyRowFf  <= 2'h0;
                end
                KP_SEEK: begin
                    if (scanTick && |keypadSense) begin
                        candKeyFf   <= {keyRowFf, lowestBit(keypadSense)};
                        stableCntFf <= 4'h1;
                        kpStateFf   <= KP_STABLE;
                    end
                end
                KP_STABLE: begin
                    if (scanTick && candLost) begin
                        kpStateFf <= KP_SEEK;
                    end else if (keyAccept) begin
                        kpStateFf <= KP_HELD;
                    end else if (scanTick) begin
                        stableCntFf <= stableCntFf + 4'h1;
                    end
                end
                KP_HELD: begin
                    if (scanTick && candLost) begin
                        kpStateFf <= KP_SEEK;
                    end
                end
                default: kpStateFf <= KP_IDLE;
            endcase
            if (scanTick && kpStateFf != KP_IDLE) begin
                keyRowFf <= keyRowFf + 2'h1;
            end
        end
    end

    always_comb begin
        nxtKeyValue = accumulate(keyValueFf, candKeyFf, ctrlFf.hexEntry);
        if (ctrlFf.doubleWord) begin
            entryOvf = ctrlFf.hexEntry ? |nxtKeyValue[35:32]
                     : nxtKeyValue > DEC_LIMIT_DOUBLE;
        end else begin
            entryOvf = ctrlFf.hexEntry ? |nxtKeyValue[35:16]
                     : nxtKeyValue > DEC_LIMIT_SINGLE;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            keyValueFf <= 32'h0;
        end else if (keyAccept && (ctrlFf.hexEntry || !isLetter)) begin
            if (!entryOvf) begin
                keyValueFf <= nxtKeyValue[31:0];
            end
        end else if (wrEn && reqFf.addr == ADDR_KEY_LO) begin
            keyValueFf[15:0] <= hwdata[15:0];
        end else if (wrEn && reqFf.addr == ADDR_KEY_HI) begin
            keyValueFf[31:16] <= hwdata[15:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            funcFlagsFf <= 6'h0;
        end else if (!ctrlFf.keyDrive) begin
            funcFlagsFf <= 6'h0;
        end else if (keyAccept && isLetter && !ctrlFf.hexEntry) begin
            funcFlagsFf <= 6'h1 << (candKeyFf - 4'hA);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            keyDoneFf <= 1'b0;
            keyOvfFf  <= 1'b0;
        end else begin
            if (keyWrap) begin
                keyDoneFf <= 1'b1;
            end else if (wrEn && reqFf.addr == ADDR_KEY_STAT &&
                         hwdata[KS_DONE]) begin
                keyDoneFf <= 1'b0;
            end
            if (keyAccept && (ctrlFf.hexEntry || !isLetter) && entryOvf) begin
                keyOvfFf <= 1'b1;
            end else if (wrEn && reqFf.addr == ADDR_KEY_STAT &&
                         hwdata[KS_OVF]) begin
                keyOvfFf <= 1'b0;
            end
        end
    end

    // ========================================================================
    // Thumbwheel reader
    // ========================================================================
    assign switchStrobes = swHoldFf ? oneHot(swStepFf) : 4'h0;
    assign swStep  = swHoldFf && scanTick &&
                     swCntFf >= SW_CNT_W'(SW_INTERVAL_CYCLES - 1);
    assign swWrap  = swStep && swStepFf == LAST_STEP;
    assign nxtRaw1 = putNibble(swRaw1Ff, swStepFf, switchSense[3:0]);
    assign nxtRaw2 = putNibble(swRaw2Ff, swStepFf, switchSense[7:4]);
    assign swBadDigit = (switchSense[3:0] > BCD_MAX) ||
                        (ctrlFf.groupsTwo && switchSense[7:4] > BCD_MAX);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            swHoldFf <= 1'b0;
            swStepFf <= 2'h0;
            swCntFf  <= '0;
        end else if (!swHoldFf) begin
            if (ctrlFf.switchDrive) begin
                swHoldFf <= 1'b1;
                swStepFf <= 2'h0;
                swCntFf  <= '0;
            end
        end else if (swStep) begin
            swStepFf <= swStepFf + 2'h1;
            swCntFf  <= '0;
            if (swWrap) begin
                swHoldFf <= ctrlFf.switchDrive;
            end
        end else if (swCntFf < SW_CNT_W'(SW_INTERVAL_CYCLES - 1)) begin
            swCntFf <= swCntFf + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            swRaw1Ff <= 16'h0;
            swRaw2Ff <= 16'h0;
            swVal1Ff <= 16'h0;
            swVal2Ff <= 16'h0;
        end else if (swStep) begin
            swRaw1Ff <= nxtRaw1;
            swRaw2Ff <= nxtRaw2;
            if (swWrap) begin
                swVal1Ff <= bcdToBin(nxtRaw1);
                if (ctrlFf.groupsTwo) begin
                    swVal2Ff <= bcdToBin(nxtRaw2);
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            swDoneFf <= 1'b0;
            swErrFf  <= 1'b0;
        end else begin
            if (swWrap) begin
                swDoneFf <= 1'b1;
            end else if (wrEn && reqFf.addr == ADDR_SW_STAT &&
                         hwdata[SS_DONE]) begin
                swDoneFf <= 1'b0;
            end
            if (swStep && swBadDigit) begin
                swErrFf <= 1'b1;
            end else if (wrEn && reqFf.addr == ADDR_SW_STAT &&
                         hwdata[SS_ERR]) begin
                swErrFf <= 1'b0;
            end
        end
    end

    // ========================================================================
    // Seven-segment decoder
    // ========================================================================
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            segSrcFf <= 16'h0;
            segDstFf <= 16'h0;
        end else if (wrEn && reqFf.addr == ADDR_SEG_SRC) begin
            segSrcFf <= hwdata[15:0];
            if (ctrlFf.segPolarity) begin
                segDstFf[7:0] <= ~segPattern(hwdata[3:0]);
            end else begin
                segDstFf[7:0] <= segPattern(hwdata[3:0]);
            end
        end else if (wrEn && reqFf.addr == ADDR_SEG_DST) begin
            segDstFf[15:8] <= hwdata[15:8];
        end
    end

endmodule

// [sim/keypad_io_checker.sv]
`timescale 1ns/1ps
// ==================
// Strobe sequencing checks.
module keypad_io_checker (
    input wire logic       mclk,
    input wire logic       sys_rst,
    input wire logic       scanTick,
    input wire logic [3:0] keypadStrobes,
    input wire logic [3:0] switchStrobes
);
    logic [3:0] kpPrev;
    logic [3:0] swPrev;
    logic       tickPrev;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge mclk) begin
        kpPrev   <= keypadStrobes;
        swPrev   <= switchStrobes;
        tickPrev <= scanTick;
    end
    chk_kp_onehot: assert property ($onehot0(keypadStrobes))
        else $error("keypad strobes not one-hot");
    chk_sw_onehot: assert property ($onehot0(switchStrobes))
        else $error("switch strobes not one-hot");
    chk_kp_start: assert property (
        (kpPrev == 4'h0 && keypadStrobes != 4'h0) |-> keypadStrobes == 4'h1)
        else $error("keypad scan did not start at row 0");
    chk_sw_start: assert property (
        (swPrev == 4'h0 && switchStrobes != 4'h0) |-> switchStrobes == 4'h1)
        else $error("switch read did not start at step 0");
    chk_kp_order: assert property (
        (kpPrev != 4'h0 && keypadStrobes != 4'h0 && keypadStrobes != kpPrev)
        |-> keypadStrobes == {kpPrev[2:0], kpPrev[3]})
        else $error("keypad row out of order");
    chk_kp_tick: assert property (
        (kpPrev != 4'h0 && keypadStrobes != 4'h0 && keypadStrobes != kpPrev)
        |-> tickPrev)
        else $error("keypad row moved without tick");
    chk_sw_stable: assert property (
        (switchStrobes != 4'h0 && !scanTick) |=> $stable(switchStrobes))
        else $error("switch step moved without tick");
    chk_sw_order: assert property (
        (swPrev != 4'h0 && switchStrobes != swPrev)
        |-> switchStrobes == {swPrev[2:0], 1'b0} || swPrev == 4'h8)
        else $error("switch step out of order");
    chk_sw_end: assert property (
        (swPrev != 4'h0 && switchStrobes == 4'h0) |-> swPrev == 4'h8)
        else $error("switch cycle ended early");
endmodule
bind keypad_switch_segment_io keypad_io_checker chk (
    .mclk          (mclk),
    .sys_rst       (sys_rst),
    .scanTick      (scanTick),
    .keypadStrobes (keypadStrobes),
    .switchStrobes (switchStrobes)
);

// [sim/io_far_side.sv]
`timescale 1ns/1ps
// ==================
// Keypad matrix and thumbwheel switches.
module io_far_side (
    input  wire logic        mclk,
    input  wire logic [15:0] keysDown,
    input  wire logic [15:0] dialOne,
    input  wire logic [15:0] dialTwo,
    input  wire logic [3:0]  keypadStrobes,
    input  wire logic [3:0]  switchStrobes,
    output logic      [3:0]  keypadSense,
    output logic      [7:0]  switchSense
);
    logic [7:0] lastSw;
    always_comb begin
        keypadSense = 4'h0;
        switchSense = ~lastSw;
        for (int r = 0; r < 4; r++) begin
            if (keypadStrobes[r]) begin
                keypadSense = keypadSense | keysDown[r*4 +: 4];
            end
            if (switchStrobes[r]) begin
                switchSense = {dialTwo[r*4 +: 4], dialOne[r*4 +: 4]};
            end
        end
    end
    always_ff @(posedge mclk) begin
        lastSw <= switchSense;
    end
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module testbench import keypad_io_pkg::*;;
    localparam logic [127:0] SEG_TAB = {8'h71, 8'h79, 8'h5E, 8'h39, 8'h7C,
        8'h77, 8'h6F, 8'h7F, 8'h27, 8'h7D, 8'h6D, 8'h66, 8'h4F, 8'h5B,
        8'h06, 8'h3F};
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        hsel = 1'b1;
    logic        hwrite = 1'b0;
    logic        scanTick = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [1:0]  tc = 2'h0;
    logic [15:0] keysDown = 16'h0;
    logic [15:0] dialOne = 16'h0;
    logic [15:0] dialTwo = 16'h0;
    wire  logic  hready;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [3:0]  keypadSense;
    logic [3:0]  keypadStrobes;
    logic [3:0]  switchStrobes;
    logic [7:0]  switchSense;
    logic [31:0] gotData;
    logic [63:0] nt;
    logic [63:0] notes[$];
    event        gotEv;
    int          fails = 0;
    int          n_compared = 0;
    int          seed = 32'h9b06;
    assign hready = hreadyout;
    keypad_switch_segment_io #(.SW_INTERVAL_CYCLES(20)) dut (
        .mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .scanTick(scanTick), .keypadSense(keypadSense),
        .keypadStrobes(keypadStrobes), .switchSense(switchSense),
        .switchStrobes(switchStrobes));
    io_far_side far (
        .mclk(mclk), .keysDown(keysDown), .dialOne(dialOne),
        .dialTwo(dialTwo), .keypadStrobes(keypadStrobes),
        .switchStrobes(switchStrobes), .keypadSense(keypadSense),
        .switchSense(switchSense));
    // ==================
    // Clock, tick, tasks.
    initial begin
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        tc       <= tc + 2'h1;
        scanTick <= (tc == 2'h3);
    end
    task automatic tally_and_finish;
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wait_on(input logic [3:0] v);
        int k;
        k = 0;
        @(posedge mclk);
        while (switchStrobes !== v) begin
            if (++k > 1000) begin fails++; tally_and_finish; end
            @(posedge mclk);
        end
    endtask
    task automatic hold_rdy;
        int k;
        k = 0;
        @(posedge mclk);
        while (hready !== 1'b1) begin
            if (++k > 50) begin fails++; tally_and_finish; end
            @(posedge mclk);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hold_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        hold_rdy;
        if (!w) begin gotData = hrdata; ->gotEv; end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
        @(posedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] v);
        notes.push_back({m, v});
        bus(a, 1'b0, 32'h0);
    endtask
    task automatic ticks(input int n);
        repeat (n * 4) @(posedge mclk);
    endtask
    task automatic press(input int k, input logic [15:0] extra, input int held,
                         input logic [31:0] m, input logic [31:0] v);
        keysDown <= 16'h1 << k;
        ticks(5);
        keysDown <= (16'h1 << k) | extra;
        ticks(held);
        if (m != 32'h0) rd(ADDR_KEY_STAT, m, v);
        keysDown <= 16'h0;
        ticks(8);
    endtask
    initial begin
        forever begin
            @(gotEv);
            nt = notes.pop_front();
            `CHK(gotData & nt[63:32], nt[31:0])
            `CHK(hresp, 1'b0)
        end
    end
    // ==================
    // Main sequence.
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        for (int a = 0; a <= 32; a += 4) rd(8'(a), 32'hFFFFFFFF, 32'h0);
        wr(8'h20, 32'hFFFFFFFF);
        rd(ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
        wr(ADDR_SEG_DST, 32'h5A00);
        for (int p = 0; p < 2; p++) begin
            wr(ADDR_CTRL, 32'(p) << 5);
            for (int n = 0; n < 16; n++) begin
                wr(ADDR_SEG_SRC, ({$random(seed)} << 4) | 32'(n));
                rd(ADDR_SEG_DST, 32'hFFFF,
                   {16'h5A, p ? ~SEG_TAB[n*8 +: 8] : SEG_TAB[n*8 +: 8]});
            end
        end
        wr(ADDR_CTRL, 32'h1);
        press(2, 16'h0, 10, 32'hC0, 32'h80);
        press(1, 16'h0, 10, 32'h0, 32'h0);
        press(3, 16'h0100, 10, 32'h0, 32'h0);
        press(0, 16'h0, 10, 32'h100, 32'h100);
        rd(ADDR_KEY_LO, 32'hFFFF, 32'h0852);
        wr(ADDR_KEY_LO, 32'h270F);
        press(1, 16'h0, 10, 32'h200, 32'h200);
        press(4, 16'h0, 0, 32'h0, 32'h0);
        rd(ADDR_KEY_LO, 32'hFFFF, 32'h270F);
        wr(ADDR_CTRL, 32'h3);
        wr(ADDR_KEY_LO, 32'h967F);
        wr(ADDR_KEY_HI, 32'h0098);
        wr(ADDR_KEY_STAT, 32'h300);
        press(9, 16'h0, 10, 32'h200, 32'h0);
        rd(ADDR_KEY_LO, 32'hFFFF, 32'hE0FF);
        press(9, 16'h0, 10, 32'h200, 32'h200);
        rd(ADDR_KEY_HI, 32'hFFFF, 32'h05F5);
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_KEY_LO, 32'h1234);
        press(10, 16'h0, 10, 32'h7F, 32'h41);
        press(13, 16'h0, 10, 32'h3F, 32'h08);
        wr(ADDR_CTRL, 32'h0);
        rd(ADDR_KEY_STAT, 32'hFF, 32'h0);
        rd(ADDR_KEY_LO, 32'hFFFF, 32'h1234);
        wr(ADDR_CTRL, 32'h5);
        wr(ADDR_KEY_LO, 32'h0);
        wr(ADDR_KEY_HI, 32'h0);
        press(11, 16'h0, 10, 32'h0, 32'h0);
        press(15, 16'h0, 10, 32'h0, 32'h0);
        rd(ADDR_KEY_LO, 32'hFFFF, 32'h00BF);
        dialOne <= 16'h4321;
        dialTwo <= 16'h0987;
        wr(ADDR_CTRL, 32'h18);
        wr(ADDR_CTRL, 32'h10);
        rd(ADDR_SW_STAT, 32'h4, 32'h4);
        wait_on(4'h8);
        wait_on(4'h0);
        rd(ADDR_SW_STAT, 32'h7, 32'h1);
        rd(ADDR_SW_VAL, 32'hFFFFFFFF, 32'h03DB10E1);
        dialOne <= 16'h5A21;
        wr(ADDR_SW_STAT, 32'h3);
        wr(ADDR_CTRL, 32'h08);
        wait_on(4'h8);
        wait_on(4'h1);
        rd(ADDR_SW_STAT, 32'h7, 32'h7);
        wr(ADDR_CTRL, 32'h0);
        wait_on(4'h0);
        rd(ADDR_SW_VAL, 32'hFFFFFFFF, 32'h03DB1785);
        sys_rst <= 1'b1;
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rd(ADDR_SW_VAL, 32'hFFFFFFFF, 32'h0);
        repeat (4) @(posedge mclk);
        tally_and_finish;
    end
endmodule
